// [hw/iflr_pkg.sv]
// Package: command codes, reset values and timing for the input limit bank
package iflr_pkg;

   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_INPUT_OV_LIMIT = 8'h55;
   localparam logic [7:0] CMD_INPUT_UV_LIMIT = 8'h59;
   localparam logic [7:0] CMD_INPUT_OC_LIMIT = 8'h5b;
   localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
   localparam logic [7:0] CMD_COMMIT_PENDING_CONFIG = 8'he7;

   // ==========================================================
   // Widths and page count
   localparam int DATA_W = 16;
   localparam int NUM_PAGES = 2;

   // ==========================================================
   // Values after reset
   localparam logic [15:0] RST_INPUT_OV_LIMIT = 16'h36b0;
   localparam logic [15:0] RST_INPUT_UV_LIMIT = 16'h1f40;
   localparam logic [15:0] RST_INPUT_OC_LIMIT = 16'h0032;
   localparam logic [15:0] RST_TURN_ON_DELAY = 16'h0014;
   localparam logic [15:0] ZERO_WORD = 16'h0000;

   // ==========================================================
   // Timing: one delay step and the clock period
   localparam int DELAY_STEP_NS = 10000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 9;
   localparam logic [PRESC_W-1:0] PRESC_LAST =
      PRESC_W'(STEP_CYCLES - 1);
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 9'h000;

   // ==========================================================
   // Turn-on sequencer states
   typedef enum logic [2:0] {
      IFLR_TON_IDLE = 3'h1,
      IFLR_TON_WAIT = 3'h2,
      IFLR_TON_RAMP = 3'h4
   } iflr_ton_e;

endpackage : iflr_pkg

// [hw/iflr_ton_timer.sv]
// Module: per-page turn-on delay timer counting 10 us steps
module iflr_ton_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic out_enable,
   input wire logic [15:0] delay_code,
   output logic ramp_start,
   output logic ramp_active
);

   // ==========================================================
   // State
   iflr_pkg::iflr_ton_e state_r, state_nxt;
   logic [15:0] steps_r, steps_nxt;
   logic [iflr_pkg::PRESC_W-1:0] presc_r, presc_nxt;
   logic start_r, start_nxt;

   // Next state; delay is latched at enable so later writes do not
   // stretch or cut a delay already running
   always_comb begin
      state_nxt = state_r;
      steps_nxt = steps_r;
      presc_nxt = presc_r;
      start_nxt = 1'b0;
      unique case (state_r)
         iflr_pkg::IFLR_TON_IDLE: begin
            if (out_enable) begin
               steps_nxt = delay_code; // [R8]
               presc_nxt = iflr_pkg::PRESC_LAST;
               state_nxt = iflr_pkg::IFLR_TON_WAIT;
            end
         end
         iflr_pkg::IFLR_TON_WAIT: begin
            if (!out_enable) begin
               state_nxt = iflr_pkg::IFLR_TON_IDLE;
            end else if (steps_r == iflr_pkg::ZERO_WORD) begin
               state_nxt = iflr_pkg::IFLR_TON_RAMP;
               start_nxt = 1'b1;
            end else if (presc_r == iflr_pkg::PRESC_ZERO) begin
               presc_nxt = iflr_pkg::PRESC_LAST; // 500 cycles a step [R8]
               steps_nxt = steps_r - 16'h0001;
            end else begin
               presc_nxt = presc_r - 9'h001;
            end
         end
         iflr_pkg::IFLR_TON_RAMP: begin
            if (!out_enable) begin
               state_nxt = iflr_pkg::IFLR_TON_IDLE;
            end
         end
         default: begin
            state_nxt = iflr_pkg::IFLR_TON_IDLE;
         end
      endcase
   end

   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= iflr_pkg::IFLR_TON_IDLE;
         steps_r <= iflr_pkg::ZERO_WORD;
         presc_r <= iflr_pkg::PRESC_ZERO;
         start_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         steps_r <= steps_nxt;
         presc_r <= presc_nxt;
         start_r <= start_nxt;
      end
   end

   // Outputs
   assign ramp_start = start_r;
   assign ramp_active = (state_r == iflr_pkg::IFLR_TON_RAMP);

endmodule : iflr_ton_timer

// [hw/iflr_top.sv]
// Module: input fault limit and turn-on delay command bank
//
// Behaviour
// R1 - Each of the four settings is a 16-bit read/write unsigned integer.
// R2 - Input overvoltage limit is global, in mV, resets to 36B0h (14,000 mV).
// R3 - The three limits take effect only after the commit command.
// R4 - Input undervoltage limit is global, in mV, resets to 1F40h (8,000 mV).
// R5 - Input below the undervoltage limit raises the low input lockout.
// R6 - Input overcurrent limit is global, in amperes, resets to 0032h (50 A).
// R7 - Turn-on delay is held per page and resets to 0014h (200 us).
// R8 - Turn-on delay code counts 10 us steps; host keeps it in range.
// R9 - Reads return the last written limit; comparators use applied limits.
//
// ==========================================================
// Command map
//   55h input_overvoltage_limit: global, staged
//   59h input_undervoltage_limit: global, staged
//   5Bh input_overcurrent_limit: global, staged
//   60h turn_on_delay: one word per page, live
//   E7h commit_pending_config: write only, data ignored
//   Any other code: no state change, unsupported pulse
//   Read of the commit code counts as unsupported
//
// ==========================================================
// Command port timing
//   Taken on a rising edge with cmd_valid high
//   Write lands in its register at that same edge
//   rd_valid and cmd_unsupported one cycle later, one cycle wide
//   rd_data holds until the next read
//   Unknown read answers zero, with rd_valid
//   A new command on every cycle is fine
//
// ==========================================================
// Staged limits
//   Pending and applied copy for each of the three limits
//   Reads show the pending copy
//   Comparators only ever see the applied copy
//   Commit copies all three on its taking edge
//   Why: software can stage a full set and switch at once,
//   so no fault is judged against a half-updated set
//
// ==========================================================
// Values after reset
//   input_overvoltage_limit 36B0h, 14,000 mV
//   input_undervoltage_limit 1F40h, 8,000 mV
//   input_overcurrent_limit 0032h, 50 A
//   turn_on_delay 0014h, 200 us, both pages
//   Pending and applied copies reset alike, so faults are
//   judged against the defaults before any commit
//   Read data register resets to zero
//
// ==========================================================
// Fault comparators
//   Strict compares on every edge, one cycle of latency
//   Overvoltage, overcurrent: sample above the limit
//   Lockout: voltage sample below the limit
//   No filter or hysteresis; downstream fault logic owns
//   debounce and response
//
// ==========================================================
// Turn-on delay
//   One timer per page, started by the enable level
//   Code latched at enable; a write during the wait only
//   counts from the next enable
//   Step of 500 clocks, 10 us at 50 MHz
//   Ramp start code x 500 + 1 clocks after the taking edge
//   Enable low at any time aborts back to idle
//
// ==========================================================
// Limitations
//   Byte pairing and bus protocol live upstream
//   Page select only steers turn_on_delay
//   No range check: values beyond the nominal spans are
//   stored and used as written; the host keeps them in range
module iflr_top (
   input wire logic clk,
   input wire logic rst_n,
   // Decoded management commands
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic cmd_page,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic cmd_unsupported,
   // Input samples and per-page enables
   input wire logic [15:0] vin_mv,
   input wire logic [15:0] iin_a,
   input wire logic [1:0] out_enable,
   // Fault levels and sequencing
   output logic input_ov_fault,
   output logic low_input_lockout,
   output logic input_oc_fault,
   output logic [1:0] ramp_start,
   output logic [1:0] ramp_active,
   // Limits the comparators use now
   output logic [15:0] applied_ov_limit,
   output logic [15:0] applied_uv_limit,
   output logic [15:0] applied_oc_limit
);

   // ==========================================================
   // Declarations
   // Staged and applied limit words
   logic [15:0] pend_ov_r, pend_ov_nxt;
   logic [15:0] pend_uv_r, pend_uv_nxt;
   logic [15:0] pend_oc_r, pend_oc_nxt;
   logic [15:0] act_ov_r, act_ov_nxt;
   logic [15:0] act_uv_r, act_uv_nxt;
   logic [15:0] act_oc_r, act_oc_nxt;
   // Turn-on delay words, one per page
   logic [15:0] ton_r [iflr_pkg::NUM_PAGES];
   logic [15:0] ton_nxt [iflr_pkg::NUM_PAGES];
   // Answer and fault registers
   logic [15:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic unsup_r, unsup_nxt;
   logic ov_r, ov_nxt;
   logic uv_r, uv_nxt;
   logic oc_r, oc_nxt;
   // Decoded strobes
   logic wr_en;
   logic rd_en;
   logic code_known;

   // ==========================================================
   // Command decode
   // Strobes qualified once so the write and read paths agree
   assign wr_en = cmd_valid && cmd_write;
   assign rd_en = cmd_valid && !cmd_write;
   always_comb begin
      unique case (cmd_code)
         iflr_pkg::CMD_INPUT_OV_LIMIT,
         iflr_pkg::CMD_INPUT_UV_LIMIT,
         iflr_pkg::CMD_INPUT_OC_LIMIT,
         iflr_pkg::CMD_TURN_ON_DELAY: code_known = 1'b1;
         iflr_pkg::CMD_COMMIT_PENDING_CONFIG: code_known = cmd_write;
         default: code_known = 1'b0;
      endcase
   end

   // ==========================================================
   // Pending limits: what the host last wrote
   always_comb begin
      pend_ov_nxt = pend_ov_r;
      pend_uv_nxt = pend_uv_r;
      pend_oc_nxt = pend_oc_r;
      if (wr_en) begin
         if (cmd_code == iflr_pkg::CMD_INPUT_OV_LIMIT) begin
            pend_ov_nxt = cmd_wdata; // [R1] [R2]
         end
         if (cmd_code == iflr_pkg::CMD_INPUT_UV_LIMIT) begin
            pend_uv_nxt = cmd_wdata; // [R1] [R4]
         end
         if (cmd_code == iflr_pkg::CMD_INPUT_OC_LIMIT) begin
            pend_oc_nxt = cmd_wdata; // [R1] [R6]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_ov_r <= iflr_pkg::RST_INPUT_OV_LIMIT; // [R2]
         pend_uv_r <= iflr_pkg::RST_INPUT_UV_LIMIT; // [R4]
         pend_oc_r <= iflr_pkg::RST_INPUT_OC_LIMIT; // [R6]
      end else begin
         pend_ov_r <= pend_ov_nxt;
         pend_uv_r <= pend_uv_nxt;
         pend_oc_r <= pend_oc_nxt;
      end
   end

   // ==========================================================
   // Applied limits: copied from pending only on commit
   // Keeping two copies lets software stage all three limits and
   // switch them over together, avoiding a half-updated window
   always_comb begin
      act_ov_nxt = act_ov_r;
      act_uv_nxt = act_uv_r;
      act_oc_nxt = act_oc_r;
      if (wr_en && cmd_code == iflr_pkg::CMD_COMMIT_PENDING_CONFIG) begin
         act_ov_nxt = pend_ov_r; // [R3]
         act_uv_nxt = pend_uv_r; // [R3]
         act_oc_nxt = pend_oc_r; // [R3]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_ov_r <= iflr_pkg::RST_INPUT_OV_LIMIT;
         act_uv_r <= iflr_pkg::RST_INPUT_UV_LIMIT;
         act_oc_r <= iflr_pkg::RST_INPUT_OC_LIMIT;
      end else begin
         act_ov_r <= act_ov_nxt;
         act_uv_r <= act_uv_nxt;
         act_oc_r <= act_oc_nxt;
      end
   end

   // ==========================================================
   // Turn-on delay, one word per page, no commit needed
   always_comb begin
      for (int p = 0; p < iflr_pkg::NUM_PAGES; p++) begin
         ton_nxt[p] = ton_r[p];
         if (wr_en && cmd_code == iflr_pkg::CMD_TURN_ON_DELAY &&
             int'(cmd_page) == p) begin
            ton_nxt[p] = cmd_wdata; // [R1] [R7]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < iflr_pkg::NUM_PAGES; p++) begin
            ton_r[p] <= iflr_pkg::RST_TURN_ON_DELAY; // [R7]
         end
      end else begin
         for (int p = 0; p < iflr_pkg::NUM_PAGES; p++) begin
            ton_r[p] <= ton_nxt[p];
         end
      end
   end

   // ==========================================================
   // Read path and unsupported-command flag
   // Answer one cycle after the request; unknown codes read zero
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      unsup_nxt = 1'b0;
      if (cmd_valid && !code_known) begin
         unsup_nxt = 1'b1;
      end
      if (rd_en) begin
         rvalid_nxt = 1'b1;
         unique case (cmd_code)
            iflr_pkg::CMD_INPUT_OV_LIMIT: rdata_nxt = pend_ov_r; // [R9]
            iflr_pkg::CMD_INPUT_UV_LIMIT: rdata_nxt = pend_uv_r; // [R9]
            iflr_pkg::CMD_INPUT_OC_LIMIT: rdata_nxt = pend_oc_r; // [R9]
            iflr_pkg::CMD_TURN_ON_DELAY: rdata_nxt = ton_r[cmd_page];
            default: rdata_nxt = iflr_pkg::ZERO_WORD;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= iflr_pkg::ZERO_WORD;
         rvalid_r <= 1'b0;
         unsup_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         unsup_r <= unsup_nxt;
      end
   end

   // ==========================================================
   // Fault comparators against the applied limits only
   // Registered so a glitching sample input does not race the outputs
   always_comb begin
      ov_nxt = (vin_mv > act_ov_r); // [R9]
      uv_nxt = (vin_mv < act_uv_r); // [R5] [R9]
      oc_nxt = (iin_a > act_oc_r); // [R9]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ov_r <= 1'b0;
         uv_r <= 1'b0;
         oc_r <= 1'b0;
      end else begin
         ov_r <= ov_nxt;
         uv_r <= uv_nxt;
         oc_r <= oc_nxt;
      end
   end

   // ==========================================================
   // Per-page turn-on timers
   for (genvar g = 0; g < iflr_pkg::NUM_PAGES; g++) begin : g_ton
      iflr_ton_timer u_ton (
         .clk(clk),
         .rst_n(rst_n),
         .out_enable(out_enable[g]),
         .delay_code(ton_r[g]),
         .ramp_start(ramp_start[g]),
         .ramp_active(ramp_active[g])
      );
   end

   // ==========================================================
   // Outputs
   assign rd_data = rdata_r;
   assign rd_valid = rvalid_r;
   assign cmd_unsupported = unsup_r;
   assign input_ov_fault = ov_r;
   assign low_input_lockout = uv_r;
   assign input_oc_fault = oc_r;
   assign applied_ov_limit = act_ov_r;
   assign applied_uv_limit = act_uv_r;
   assign applied_oc_limit = act_oc_r;

endmodule : iflr_top

// [verif/iflr_checker.sv]
// Checker: properties of the input limit bank at its ports
module iflr_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic cmd_page,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic cmd_unsupported,
   input wire logic [15:0] vin_mv,
   input wire logic [15:0] iin_a,
   input wire logic [1:0] out_enable,
   input wire logic input_ov_fault,
   input wire logic low_input_lockout,
   input wire logic input_oc_fault,
   input wire logic [1:0] ramp_start,
   input wire logic [1:0] ramp_active,
   input wire logic [15:0] applied_ov_limit,
   input wire logic [15:0] applied_uv_limit,
   input wire logic [15:0] applied_oc_limit
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Command decode helpers
   logic cmt;
   logic known;
   assign cmt = cmd_valid && cmd_write &&
      cmd_code == iflr_pkg::CMD_COMMIT_PENDING_CONFIG;
   assign known = cmd_code inside {iflr_pkg::CMD_INPUT_OV_LIMIT,
      iflr_pkg::CMD_INPUT_UV_LIMIT, iflr_pkg::CMD_INPUT_OC_LIMIT,
      iflr_pkg::CMD_TURN_ON_DELAY};
   // ==========================================================
   // Applied limits move only behind a commit
   property p_ov_hold;
      $changed(applied_ov_limit) |-> $past(cmt);
   endproperty
   a_ov_hold: assert property (p_ov_hold)
      else $error("ov limit moved without commit");
   property p_uv_hold;
      $changed(applied_uv_limit) |-> $past(cmt);
   endproperty
   a_uv_hold: assert property (p_uv_hold)
      else $error("uv limit moved without commit");
   property p_oc_hold;
      $changed(applied_oc_limit) |-> $past(cmt);
   endproperty
   a_oc_hold: assert property (p_oc_hold)
      else $error("oc limit moved without commit");
   // ==========================================================
   // Comparators, one cycle behind inputs
   property p_ov_cmp;
      input_ov_fault == ($past(vin_mv) > $past(applied_ov_limit));
   endproperty
   a_ov_cmp: assert property (p_ov_cmp)
      else $error("ov fault wrong");
   property p_uv_cmp;
      low_input_lockout == ($past(vin_mv) < $past(applied_uv_limit));
   endproperty
   a_uv_cmp: assert property (p_uv_cmp)
      else $error("lockout wrong");
   property p_oc_cmp;
      input_oc_fault == ($past(iin_a) > $past(applied_oc_limit));
   endproperty
   a_oc_cmp: assert property (p_oc_cmp)
      else $error("oc fault wrong");
   // ==========================================================
   // Command answers
   property p_rd;
      cmd_valid && !cmd_write && known |=> rd_valid && !cmd_unsupported;
   endproperty
   a_rd: assert property (p_rd)
      else $error("read not answered");
   property p_unk;
      cmd_valid && !known && !cmt |=> cmd_unsupported;
   endproperty
   a_unk: assert property (p_unk)
      else $error("unknown code accepted");
   // ==========================================================
   // Turn-on sequencing on page 0; covers for commit, page 1 ramp start and ov fault
   property p_ramp;
      $rose(ramp_active[0]) |-> ramp_start[0];
   endproperty
   a_ramp: assert property (p_ramp)
      else $error("ramp rose without start");
   property p_off;
      !out_enable[0] [*2] |-> !ramp_active[0];
   endproperty
   a_off: assert property (p_off)
      else $error("ramp stays without enable");
   c_commit: cover property (cmt);
   c_start: cover property (ramp_start[1]);
   c_fault: cover property ($rose(input_ov_fault));
endmodule : iflr_checker

bind iflr_top iflr_checker u_chk (.*);

// [verif/iflr_host.sv]
// Partner: management host issuing decoded commands
module iflr_host (
   input wire logic clk,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   output logic cmd_page,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      cmd_page = 1'b0;
   end
   // One command, strobe held over exactly one edge
   task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, input logic p, output logic [15:0] q);
      @(posedge clk);
      #1;
      if (c == iflr_pkg::CMD_TURN_ON_DELAY && d < 16'h0014)
         d = 16'h0014; // Never below the minimum delay
      if (c == iflr_pkg::CMD_TURN_ON_DELAY && d > 16'hfffe)
         d = 16'hfffe; // Never above the longest delay
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code = c;
      cmd_wdata = d;
      cmd_page = p;
      @(posedge clk);
      #1;
      q = rd_valid ? rd_data : 16'hxxxx;
      cmd_valid = 1'b0;
      cmd_wdata = ~d; // Idle data never repeats the last word
   endtask : xfer
   // Limits only count once committed
   task automatic commit;
      logic [15:0] q;
      xfer(1'b1, iflr_pkg::CMD_COMMIT_PENDING_CONFIG, 16'h0000, 1'b0, q);
   endtask : commit
endmodule : iflr_host

// [verif/iflr_top_test.sv]
// Testbench: limit bank, commit and turn-on delay scenarios
module iflr_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, cmd_valid, cmd_write, cmd_page, rd_valid, cmd_unsupported;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rd_data, vin_mv, iin_a, ov, uv, oc, q;
   logic [1:0] out_enable, ramp_start, ramp_active;
   logic ovf, lock, ocf;
   int bad_count = 0;
   int tests_run = 0;
   iflr_top DUT (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .cmd_page(cmd_page), .rd_data(rd_data), .rd_valid(rd_valid),
      .cmd_unsupported(cmd_unsupported), .vin_mv(vin_mv), .iin_a(iin_a),
      .out_enable(out_enable), .input_ov_fault(ovf),
      .low_input_lockout(lock), .input_oc_fault(ocf),
      .ramp_start(ramp_start), .ramp_active(ramp_active),
      .applied_ov_limit(ov), .applied_uv_limit(uv), .applied_oc_limit(oc));
   iflr_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_page(cmd_page),
      .rd_data(rd_data), .rd_valid(rd_valid));
   // ==========================================================
   // Clock, checking and verdict
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // Whole run is near 21k cycles; cut off at 35k
   initial begin
      #700000;
      bad_count++;
      give_verdict();
   end
   // ==========================================================
   // Scenarios
   task automatic t_defaults;
      host.xfer(0, iflr_pkg::CMD_INPUT_OV_LIMIT, 16'h0, 0, q);
      chk(q, 16'h36b0);
      host.xfer(0, iflr_pkg::CMD_INPUT_UV_LIMIT, 16'h0, 0, q);
      chk(q, 16'h1f40);
      host.xfer(0, iflr_pkg::CMD_INPUT_OC_LIMIT, 16'h0, 0, q);
      chk(q, 16'h0032);
      host.xfer(0, iflr_pkg::CMD_TURN_ON_DELAY, 16'h0, 1, q);
      chk(q, 16'h0014);
      chk(ov, 16'h36b0);
      chk(uv, 16'h1f40);
      chk(oc, 16'h0032);
      chk({13'h0, ovf, lock, ocf}, 16'h0);
      $display("t_defaults done");
   endtask : t_defaults
   task automatic t_commit;
      host.xfer(1, iflr_pkg::CMD_INPUT_OV_LIMIT, 16'h1000, 0, q);
      host.xfer(1, iflr_pkg::CMD_INPUT_UV_LIMIT, 16'h2000, 0, q);
      host.xfer(1, iflr_pkg::CMD_INPUT_OC_LIMIT, 16'h0010, 0, q);
      host.xfer(0, iflr_pkg::CMD_INPUT_UV_LIMIT, 16'h0, 0, q);
      chk(q, 16'h2000);
      chk(uv, 16'h1f40);
      chk(ov, 16'h36b0);
      chk(oc, 16'h0032);
      chk({13'h0, ovf, lock, ocf}, 16'h0);
      host.commit();
      chk(ov, 16'h1000);
      chk(uv, 16'h2000);
      chk(oc, 16'h0010);
      vin_mv = 16'h1001;
      iin_a = 16'h0011;
      repeat (2) @(posedge clk);
      #1;
      chk({13'h0, ovf, lock, ocf}, 16'h7);
      vin_mv = 16'h2000; // Both edges are strict
      iin_a = 16'h0010;
      repeat (2) @(posedge clk);
      #1;
      chk({13'h0, ovf, lock, ocf}, 16'h4);
      $display("t_commit done");
   endtask : t_commit
   task automatic t_unknown;
      host.xfer(0, 8'h56, 16'h0, 0, q);
      chk({15'h0, cmd_unsupported}, 16'h1);
      chk(q, 16'h0000);
      host.xfer(0, iflr_pkg::CMD_COMMIT_PENDING_CONFIG, 16'h0, 0, q);
      chk({15'h0, cmd_unsupported}, 16'h1);
      chk(q, 16'h0000);
      host.xfer(1, 8'h56, 16'h1234, 0, q);
      chk({15'h0, cmd_unsupported}, 16'h1);
      $display("t_unknown done");
   endtask : t_unknown
   task automatic t_ton;
      int n, n0, n1;
      n0 = 0;
      n1 = 0;
      host.xfer(1, iflr_pkg::CMD_TURN_ON_DELAY, 16'h0015, 1, q);
      host.xfer(0, iflr_pkg::CMD_TURN_ON_DELAY, 16'h0, 0, q);
      chk(q, 16'h0014);
      @(posedge clk);
      #1;
      out_enable = 2'b11;
      for (n = 1; n <= 11000; n++) begin
         @(posedge clk);
         #1;
         if (ramp_start[0]) n0 = n;
         if (ramp_start[1]) n1 = n;
      end
      chk(16'(n0), 16'(20 * 500 + 2));
      chk(16'(n1), 16'(21 * 500 + 2));
      chk({14'h0, ramp_active}, 16'h3);
      out_enable = 2'b00;
      repeat (2) @(posedge clk);
      #1;
      chk({14'h0, ramp_active}, 16'h0);
      $display("t_ton done");
   endtask : t_ton
   // Abort mid-wait, then restart with a write landing during the wait
   task automatic t_abort;
      time t0, t1;
      t1 = 0;
      out_enable = 2'b01;
      repeat (100) @(posedge clk);
      #1;
      out_enable = 2'b00;
      repeat (2) @(posedge clk);
      #1;
      out_enable = 2'b01;
      t0 = $time;
      host.xfer(1, iflr_pkg::CMD_TURN_ON_DELAY, 16'h0030, 0, q);
      repeat (10100) begin
         @(posedge clk);
         #1;
         if (ramp_start[0]) t1 = $time;
      end
      chk(16'((t1 - t0) / 20), 16'(20 * 500 + 2));
      out_enable = 2'b00;
      $display("t_abort done");
   endtask : t_abort
   // Main sequence
   initial begin
      rst_n = 1'b0;
      vin_mv = 16'h2ee0;
      iin_a = 16'h0010;
      out_enable = 2'b00;
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_defaults();
      t_commit();
      t_unknown();
      t_ton();
      t_abort();
      give_verdict();
   end
endmodule : iflr_top_test
